/* File: design/peer_match_if.sv */
`timescale 1ns/10ps
// carries a lookup key to the peer matcher and its answer back
interface peer_match_if;
    logic [synth_loss_pkg::ENDPOINT_ID_W-1:0] key;
    logic hit;
    logic [synth_loss_pkg::PEER_IDX_W-1:0] row;
    modport requester (output key, input hit, input row);
    modport matcher (input key, output hit, output row);
endinterface : peer_match_if

/* File: design/peer_matcher.sv */
`timescale 1ns/10ps
// combinational search of the peer list, lowest matching row wins
module peer_matcher #(
    parameter int PEERS = synth_loss_pkg::PEER_COUNT
) (
    // peer list
    input wire logic [PEERS-1:0] peer_entry_valid,
    input wire logic [PEERS*synth_loss_pkg::ENDPOINT_ID_W-1:0] peer_endpoint_id,
    // lookup
    peer_match_if.matcher lookup
);
    logic [PEERS-1:0] row_hit;

    // per-row compare on endpoint identifier only
    genvar g;
    generate
        for (g = 0; g < PEERS; g++) begin : g_row
            assign row_hit[g] = peer_entry_valid[g] &&
                (peer_endpoint_id[g*synth_loss_pkg::ENDPOINT_ID_W +:
                    synth_loss_pkg::ENDPOINT_ID_W] == lookup.key);
        end
    endgenerate

    // priority encode the hit rows
    always_comb begin
        lookup.hit = |row_hit;
        lookup.row = '0;
        for (int i = PEERS - 1; i >= 0; i--) begin
            if (row_hit[i]) begin
                lookup.row = synth_loss_pkg::PEER_IDX_W'(i);
            end
        end
    end
endmodule : peer_matcher

/* File: design/synth_loss_engine.sv */
`timescale 1ns/10ps
module synth_loss_engine #(
    parameter int PEERS = synth_loss_pkg::PEER_COUNT,
    parameter int CNT_W = synth_loss_pkg::CNT_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // configuration
    input wire logic synthetic_loss_enable,
    input wire logic [PEERS-1:0] peer_entry_valid,
    input wire logic [PEERS*synth_loss_pkg::ENDPOINT_ID_W-1:0] peer_endpoint_id,
    input wire logic [synth_loss_pkg::TEST_ID_W-1:0] session_test_id,
    input wire logic [synth_loss_pkg::ENDPOINT_ID_W-1:0] own_endpoint_id,
    input wire logic [synth_loss_pkg::PRIO_W-1:0] session_priority,
    input wire logic validation_error_extract,
    input wire logic loss_request_hw_enable,
    input wire logic loss_reply_hw_enable,
    // hierarchy status of server layer and port engines
    input wire logic server_synthetic_enable,
    input wire logic port_synthetic_enable,
    // pdu lookup, one per cycle while pdu_valid is high
    input wire logic pdu_valid,
    input wire logic pdu_is_tx,
    input wire synth_loss_pkg::pdu_kind_t pdu_kind,
    input wire logic [synth_loss_pkg::PRIO_W-1:0] class_of_service_id,
    input wire logic pdu_green,
    input wire logic [synth_loss_pkg::ENDPOINT_ID_W-1:0] source_endpoint_id,
    input wire logic [synth_loss_pkg::ENDPOINT_ID_W-1:0] responder_endpoint_id,
    input wire logic [synth_loss_pkg::TEST_ID_W-1:0] pdu_test_id,
    // sticky clear, one bit per sticky
    input wire logic [synth_loss_pkg::ERR_W-1:0] err_sticky_clear,
    input wire logic [synth_loss_pkg::RXS_W-1:0] rx_sticky_clear,
    // lookup answer
    output logic result_valid,
    output logic result_ok,
    output logic [synth_loss_pkg::PEER_IDX_W-1:0] peer_row_index,
    output logic result_hw_process,
    output logic error_queue_copy,
    output logic server_count_data,
    output logic port_count_data,
    // status
    output logic [synth_loss_pkg::ERR_W-1:0] err_sticky,
    output logic [synth_loss_pkg::RXS_W-1:0] rx_sticky,
    output logic [CNT_W-1:0] synth_tx_frame_count,
    output logic [PEERS*CNT_W-1:0] peer_tx_loss_count,
    output logic [PEERS*CNT_W-1:0] peer_rx_loss_count
);
    // lookup key selection and matcher
    peer_match_if lookup();
    logic is_slm;
    logic is_slr;
    logic is_1sl;
    logic is_synth;
    logic prio_ok;
    logic own_ok;
    logic test_ok;
    logic [synth_loss_pkg::ERR_W-1:0] fail;
    logic ok;
    logic [synth_loss_pkg::ERR_W-1:0] err_sticky_ff;
    logic [synth_loss_pkg::RXS_W-1:0] rx_sticky_ff;
    logic [synth_loss_pkg::RXS_W-1:0] rx_set;
    logic [CNT_W-1:0] tx_frm_ff;
    logic [CNT_W-1:0] tx_loss_ff [PEERS];
    logic [CNT_W-1:0] rx_loss_ff [PEERS];
    logic count_tx_peer;
    logic count_rx_peer;
    logic count_tx_frame;
    // decode, validation and per-row strobes
    logic rx_slr;
    logic peer_check_on;
    logic any_fail;
    logic rx_kind_ok;
    logic hw_enable_sel;
    logic [PEERS-1:0] tx_row_inc;
    logic [PEERS-1:0] rx_row_inc;

    // true for the three synthetic loss pdu kinds
    function automatic logic kind_is_synthetic(input synth_loss_pkg::pdu_kind_t kind);
        return kind == synth_loss_pkg::PDU_SLM || kind == synth_loss_pkg::PDU_SLR ||
            kind == synth_loss_pkg::PDU_1SL;
    endfunction : kind_is_synthetic

    // one-hot strobe for a peer row, shared by both per-peer counter banks
    function automatic logic [PEERS-1:0] row_onehot(
        input logic [synth_loss_pkg::PEER_IDX_W-1:0] row,
        input logic en
    );
        logic [PEERS-1:0] sel;
        sel = '0;
        for (int i = 0; i < PEERS; i++) begin
            sel[i] = en && (row == synth_loss_pkg::PEER_IDX_W'(i));
        end
        return sel;
    endfunction : row_onehot

    // pdu kind decode
    assign is_slm = pdu_kind == synth_loss_pkg::PDU_SLM;
    assign is_slr = pdu_kind == synth_loss_pkg::PDU_SLR;
    assign is_1sl = pdu_kind == synth_loss_pkg::PDU_1SL;
    assign is_synth = kind_is_synthetic(pdu_kind);
    assign rx_slr = is_slr && !pdu_is_tx;

    // the remote id is the responder id on a received slr, else the source id
    assign lookup.key = (is_slr && !pdu_is_tx) ? responder_endpoint_id
                                               : source_endpoint_id;

    // lowest valid row whose id matches wins
    peer_matcher #(
        .PEERS(PEERS)
    ) u_match (
        .peer_entry_valid(peer_entry_valid),
        .peer_endpoint_id(peer_endpoint_id),
        .lookup(lookup)
    );

    // validation checks, one failure bit per cause
    // one session priority per engine, more priorities need more engines
    assign prio_ok = class_of_service_id == session_priority;
    // the initiator's own id comes back as the source of a reply
    assign own_ok = source_endpoint_id == own_endpoint_id;
    // test id compared on replies only, the responder never looks at it
    assign test_ok = pdu_test_id == session_test_id;
    // a transmitted slm or 1sl goes out multicast and names no peer
    assign peer_check_on = !pdu_is_tx || is_slr;
    always_comb begin
        fail = '0;
        if (pdu_valid && synthetic_loss_enable && is_synth) begin
            // remote id against the peer list on all but multicast transmits
            if (peer_check_on) begin
                fail[synth_loss_pkg::ERR_UNKNOWN_PEER] = !lookup.hit;
            end
            // priority is checked on every synthetic pdu, both directions
            fail[synth_loss_pkg::ERR_PRIO] = !prio_ok;
            // own id and test id only on a reply returning to the initiator
            if (rx_slr) begin
                fail[synth_loss_pkg::ERR_OWN_ID] = !own_ok;
                fail[synth_loss_pkg::ERR_TEST_ID] = !test_ok;
            end
        end
    end

    // valid when synthetic on a synthetic engine and nothing failed
    assign any_fail = |fail;
    assign ok = pdu_valid && synthetic_loss_enable && is_synth && !any_fail;

    // counting decisions; color gate as for frame loss, no reply aging
    // per-peer transmit: a green slr leaving the responder
    assign count_tx_peer = ok && pdu_green && pdu_is_tx && is_slr;

    // per-peer receive: a green slr or 1sl arriving
    assign count_rx_peer = ok && pdu_green && !pdu_is_tx && (is_slr || is_1sl);

    // engine-wide transmit count, color not looked at
    assign count_tx_frame = ok && pdu_is_tx && (is_slm || is_1sl);

    // per-peer increment strobes, only the matched row moves
    assign tx_row_inc = row_onehot(lookup.row, count_tx_peer);
    assign rx_row_inc = row_onehot(lookup.row, count_rx_peer);

    // a synthetic pdu on a frame-loss engine still marks its kind
    assign rx_kind_ok = ok || !synthetic_loss_enable;

    // receive stickies: set for the pdu kind even on a mismatched engine
    always_comb begin
        rx_set = '0;
        if (pdu_valid && !pdu_is_tx) begin
            rx_set[synth_loss_pkg::RXS_SLM] = is_slm && rx_kind_ok;
            rx_set[synth_loss_pkg::RXS_SLR] = is_slr && rx_kind_ok;
            rx_set[synth_loss_pkg::RXS_1SL] = is_1sl && rx_kind_ok;
            rx_set[synth_loss_pkg::RXS_LMM] = pdu_kind == synth_loss_pkg::PDU_LMM;
            rx_set[synth_loss_pkg::RXS_LMR] = pdu_kind == synth_loss_pkg::PDU_LMR;
        end
    end

    // error stickies, a set in the clear cycle wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            err_sticky_ff <= synth_loss_pkg::STICKY_RST;
        end else begin
            err_sticky_ff <= (err_sticky_ff & ~err_sticky_clear) | fail;
        end
    end

    // receive stickies, a set in the clear cycle wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_sticky_ff <= '0;
        end else begin
            rx_sticky_ff <= (rx_sticky_ff & ~rx_sticky_clear) | rx_set;
        end
    end

    // single initiator transmit counter, mode decided by pdu type alone
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_frm_ff <= synth_loss_pkg::CNT_RST;
        end else if (count_tx_frame) begin
            tx_frm_ff <= tx_frm_ff + CNT_W'(1);
        end
    end

    // per-peer loss counters indexed by the matched row, not priority
    genvar p;
    generate
        for (p = 0; p < PEERS; p++) begin : g_peer
            // transmit loss counter of this row
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    tx_loss_ff[p] <= synth_loss_pkg::CNT_RST;
                end else if (tx_row_inc[p]) begin
                    tx_loss_ff[p] <= tx_loss_ff[p] + CNT_W'(1);
                end
            end

            // receive loss counter of this row
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    rx_loss_ff[p] <= synth_loss_pkg::CNT_RST;
                end else if (rx_row_inc[p]) begin
                    rx_loss_ff[p] <= rx_loss_ff[p] + CNT_W'(1);
                end
            end

            // flatten the row onto the output buses
            assign peer_tx_loss_count[p*CNT_W +: CNT_W] = tx_loss_ff[p];
            assign peer_rx_loss_count[p*CNT_W +: CNT_W] = rx_loss_ff[p];
        end
    endgenerate

    // slm uses the request enable, slr and 1sl the reply enable
    assign hw_enable_sel = is_slm ? loss_request_hw_enable : loss_reply_hw_enable;

    // registered lookup answer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            result_valid <= 1'b0;
            result_ok <= 1'b0;
            peer_row_index <= '0;
        end else begin
            result_valid <= pdu_valid;
            result_ok <= ok;
            peer_row_index <= lookup.row;
        end
    end

    // hardware processing flag, gated per pdu kind
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            result_hw_process <= 1'b0;
        end else begin
            result_hw_process <= ok && hw_enable_sel;
        end
    end

    // copy of a failed pdu to the error queue when asked for
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            error_queue_copy <= 1'b0;
        end else begin
            error_queue_copy <= validation_error_extract && any_fail;
        end
    end

    // hierarchy data counting: skipped for synthetic upper engines
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            server_count_data <= 1'b0;
            port_count_data <= 1'b0;
        end else begin
            server_count_data <= pdu_valid && pdu_green && !server_synthetic_enable;
            port_count_data <= pdu_valid && pdu_green && !port_synthetic_enable;
        end
    end

    // status outputs straight from their registers
    assign err_sticky = err_sticky_ff;
    assign rx_sticky = rx_sticky_ff;
    assign synth_tx_frame_count = tx_frm_ff;
endmodule : synth_loss_engine

/* File: design/synth_loss_pkg.sv */
package synth_loss_pkg;
    // geometry
    localparam int PEER_COUNT = 8;
    localparam int PEER_IDX_W = 3;
    localparam int ENDPOINT_ID_W = 13;
    localparam int TEST_ID_W = 32;
    localparam int PRIO_W = 3;
    localparam int CNT_W = 32;
    // reset values
    localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
    localparam logic [3:0] STICKY_RST = 4'h0;
    // error sticky bit positions
    localparam int ERR_UNKNOWN_PEER = 0;
    localparam int ERR_PRIO = 1;
    localparam int ERR_OWN_ID = 2;
    localparam int ERR_TEST_ID = 3;
    localparam int ERR_W = 4;
    // receive sticky bit positions
    localparam int RXS_SLM = 0;
    localparam int RXS_SLR = 1;
    localparam int RXS_1SL = 2;
    localparam int RXS_LMM = 3;
    localparam int RXS_LMR = 4;
    localparam int RXS_W = 5;

    // pdu kinds presented to the engine
    typedef enum logic [2:0] {
        PDU_OTHER,
        PDU_SLM,
        PDU_SLR,
        PDU_1SL,
        PDU_LMM,
        PDU_LMR
    } pdu_kind_t;
endpackage : synth_loss_pkg

/* File: sim/remote_peer.sv */
`timescale 1ns/10ps
// remote responder: builds the fields of its reply to a request
module remote_peer #(
    parameter logic [12:0] MY_ID = 13'h155
) (
    // request from the initiator
    input wire logic [12:0] initiator_id,
    input wire logic [31:0] request_test_id,
    // reply fields
    output logic [12:0] reply_source_id,
    output logic [12:0] reply_responder_id,
    output logic [31:0] reply_test_id
);
    // echo initiator id and test id, own id as responder
    assign reply_source_id = initiator_id;
    assign reply_responder_id = MY_ID;
    assign reply_test_id = request_test_id;
endmodule : remote_peer

/* File: sim/synth_loss_props.sv */
`timescale 1ns/10ps
// watches lookup answers, stickies and counters
module synth_loss_props #(
    parameter int PEERS = 8,
    parameter int CNT_W = 32
) (
    // clock, config and lookup
    input wire logic clk,
    input wire logic rst,
    input wire logic synthetic_loss_enable,
    input wire logic [PEERS-1:0] peer_entry_valid,
    input wire logic [PEERS*13-1:0] peer_endpoint_id,
    input wire logic [2:0] session_priority,
    input wire logic validation_error_extract,
    input wire logic loss_request_hw_enable,
    input wire logic server_synthetic_enable,
    input wire logic pdu_valid,
    input wire logic pdu_is_tx,
    input wire synth_loss_pkg::pdu_kind_t pdu_kind,
    input wire logic [2:0] class_of_service_id,
    input wire logic [12:0] source_endpoint_id,
    input wire logic [3:0] err_sticky_clear,
    // answers and status
    input wire logic result_valid,
    input wire logic result_ok,
    input wire logic result_hw_process,
    input wire logic error_queue_copy,
    input wire logic server_count_data,
    input wire logic [3:0] err_sticky,
    input wire logic [4:0] rx_sticky,
    input wire logic [CNT_W-1:0] synth_tx_frame_count
);
    // kind decode
    wire logic slm = pdu_kind == synth_loss_pkg::PDU_SLM;
    wire logic one = pdu_kind == synth_loss_pkg::PDU_1SL;
    wire logic syn = slm || one || pdu_kind == synth_loss_pkg::PDU_SLR;
    wire logic chk_on = pdu_valid && synthetic_loss_enable && syn;
    wire logic bad_prio = class_of_service_id != session_priority;
    logic hit;
    // peer list search on the source id
    always_comb begin
        hit = 1'b0;
        for (int r = 0; r < PEERS; r++) begin
            if (peer_entry_valid[r] && peer_endpoint_id[r*13+:13] == source_endpoint_id) begin
                hit = 1'b1;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_answer; pdu_valid |=> result_valid; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_unknown; chk_on && !pdu_is_tx && slm && !hit |=> !result_ok && err_sticky[0];
    endproperty
    a_unknown: assert property (p_unknown) else $error("unknown peer passed");
    property p_prio; chk_on && bad_prio |=> !result_ok && err_sticky[1]; endproperty
    a_prio: assert property (p_prio) else $error("priority passed");
    property p_extract; chk_on && bad_prio && validation_error_extract |=> error_queue_copy;
    endproperty
    a_extract: assert property (p_extract) else $error("no error copy");
    property p_tx_count; pdu_valid && synthetic_loss_enable && pdu_is_tx && (slm || one)
        && !bad_prio |=> synth_tx_frame_count == $past(synth_tx_frame_count) + 1; endproperty
    a_tx_count: assert property (p_tx_count) else $error("tx count");
    property p_tx_hold; !(pdu_valid && pdu_is_tx && (slm || one)) |=>
        $stable(synth_tx_frame_count); endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx count moved");
    property p_server; pdu_valid && server_synthetic_enable |=> !server_count_data; endproperty
    a_server: assert property (p_server) else $error("server counted");
    property p_lmm; pdu_valid && !pdu_is_tx && pdu_kind == synth_loss_pkg::PDU_LMM
        |=> rx_sticky[3]; endproperty
    a_lmm: assert property (p_lmm) else $error("no loss sticky");
    property p_hw; pdu_valid && slm && !loss_request_hw_enable |=> !result_hw_process;
    endproperty
    a_hw: assert property (p_hw) else $error("hw not gated");
    property p_keep; err_sticky_clear == 4'h0 |=>
        (err_sticky & $past(err_sticky)) == $past(err_sticky); endproperty
    a_keep: assert property (p_keep) else $error("sticky lost");
    // main scenarios
    c_ok: cover property (result_valid && result_ok);
    c_copy: cover property (error_queue_copy);
    c_tx: cover property (pdu_valid && pdu_is_tx && slm);
endmodule : synth_loss_props
bind synth_loss_engine synth_loss_props #(.PEERS(PEERS), .CNT_W(CNT_W)) props (.*);

/* File: sim/tb.sv */
`timescale 1ns/10ps
module tb;
    // stimulus, peers at rows 2 and 5
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic synthetic_loss_enable = 1'b1;
    logic [7:0] peer_entry_valid = 8'h24;
    logic [103:0] peer_endpoint_id = {26'h0, 13'h155, 26'h0, 13'h0A5, 26'h0};
    logic [31:0] session_test_id = 32'hCAFE_0001;
    logic [12:0] own_endpoint_id = 13'h033;
    logic [2:0] session_priority = 3'h5;
    logic validation_error_extract = 1'b1;
    logic loss_request_hw_enable = 1'b1;
    logic loss_reply_hw_enable = 1'b1;
    logic server_synthetic_enable = 1'b0;
    logic port_synthetic_enable = 1'b0;
    logic pdu_valid = 1'b0, pdu_is_tx = 1'b0, pdu_green = 1'b1;
    synth_loss_pkg::pdu_kind_t pdu_kind = synth_loss_pkg::PDU_OTHER;
    logic [2:0] class_of_service_id = 3'h0;
    logic [12:0] source_endpoint_id = 13'h0, responder_endpoint_id = 13'h0;
    logic [31:0] pdu_test_id = 32'h0;
    logic [3:0] err_sticky_clear = 4'h0;
    logic [4:0] rx_sticky_clear = 5'h0;
    // answers
    logic result_valid, result_ok, result_hw_process, error_queue_copy;
    logic server_count_data, port_count_data;
    logic [2:0] peer_row_index;
    logic [3:0] err_sticky;
    logic [4:0] rx_sticky;
    logic [31:0] synth_tx_frame_count, m_tid;
    logic [255:0] peer_tx_loss_count, peer_rx_loss_count;
    logic [12:0] m_src, m_rsp;
    int miscompares = 0, checks = 0, cycles = 0;
    synth_loss_engine uut (.*);
    remote_peer pm (.initiator_id(own_endpoint_id), .request_test_id(session_test_id),
        .reply_source_id(m_src), .reply_responder_id(m_rsp), .reply_test_id(m_tid));
    // clock and hang guard
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1500) begin
            miscompares++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
            miscompares++;
        end
    endtask : chk
    // one lookup, answer settled on return
    task automatic send(input synth_loss_pkg::pdu_kind_t kd, input logic t, input logic [2:0] c,
        input logic [12:0] s, input logic [12:0] r, input logic [31:0] i, input logic g);
        @(posedge clk);
        pdu_valid <= 1'b1;
        pdu_kind <= kd;
        pdu_is_tx <= t;
        class_of_service_id <= c;
        source_endpoint_id <= s;
        responder_endpoint_id <= r;
        pdu_test_id <= i;
        pdu_green <= g;
        @(posedge clk) pdu_valid <= 1'b0;
        #1;
        chk(result_valid, 1);
    endtask : send
    task automatic t_slr();
        send(synth_loss_pkg::PDU_SLR, 1'b0, 3'h5, m_src, m_rsp, m_tid, 1'b1);
        chk(result_ok, 1);
        chk(peer_row_index, 5);
        chk(rx_sticky, 5'h02);
        chk(peer_rx_loss_count[5*32+:32], 1);
        send(synth_loss_pkg::PDU_SLR, 1'b0, 3'h5, m_src, m_rsp, m_tid, 1'b0);
        chk(peer_rx_loss_count[5*32+:32], 1);
    endtask : t_slr
    task automatic t_bad();
        for (int n = 0; n < 5; n++) begin
            case (n)
                0: send(synth_loss_pkg::PDU_SLM, 1'b0, 3'h5, 13'h077, 13'h0, 32'h0, 1'b1);
                1: send(synth_loss_pkg::PDU_SLM, 1'b0, 3'h3, 13'h0A5, 13'h0, 32'h0, 1'b1);
                2: send(synth_loss_pkg::PDU_SLR, 1'b0, 3'h5, 13'h034, 13'h155, session_test_id, 1'b1);
                3: send(synth_loss_pkg::PDU_SLR, 1'b0, 3'h5, own_endpoint_id, 13'h155, 32'h0, 1'b1);
                default: begin
                    @(posedge clk) peer_entry_valid <= 8'h04;
                    validation_error_extract <= 1'b0;
                    send(synth_loss_pkg::PDU_SLM, 1'b0, 3'h5, 13'h155, 13'h0, 32'h0, 1'b1);
                end
            endcase
            chk(result_ok, 0);
            chk(error_queue_copy, n != 4);
            chk(err_sticky, n == 4 ? 1 : 1 << n);
            @(posedge clk) err_sticky_clear <= 4'hF;
            @(posedge clk) err_sticky_clear <= 4'h0;
            peer_entry_valid <= 8'h24;
            validation_error_extract <= 1'b1;
        end
    endtask : t_bad
    task automatic t_tx();
        send(synth_loss_pkg::PDU_SLM, 1'b1, 3'h5, 13'h0, 13'h0, 32'h0, 1'b0);
        send(synth_loss_pkg::PDU_1SL, 1'b1, 3'h5, 13'h0, 13'h0, 32'h0, 1'b1);
        chk(synth_tx_frame_count, 2);
        send(synth_loss_pkg::PDU_SLM, 1'b1, 3'h2, 13'h0, 13'h0, 32'h0, 1'b1);
        chk(result_ok, 0);
        chk(synth_tx_frame_count, 2);
        send(synth_loss_pkg::PDU_SLR, 1'b1, 3'h5, 13'h0A5, 13'h0, 32'h0, 1'b1);
        chk(peer_row_index, 2);
        chk(result_hw_process, 1);
        chk(peer_tx_loss_count[2*32+:32], 1);
        send(synth_loss_pkg::PDU_SLR, 1'b1, 3'h5, 13'h077, 13'h0, 32'h0, 1'b1);
        chk(result_ok, 0);
        @(posedge clk) loss_request_hw_enable <= 1'b0;
        send(synth_loss_pkg::PDU_SLM, 1'b1, 3'h5, 13'h0, 13'h0, 32'h0, 1'b1);
        chk(result_hw_process, 0);
        @(posedge clk) loss_request_hw_enable <= 1'b1;
    endtask : t_tx
    task automatic t_1sl();
        send(synth_loss_pkg::PDU_SLM, 1'b0, 3'h5, 13'h0A5, 13'h0, 32'h0, 1'b1);
        chk(peer_rx_loss_count[2*32+:32], 0);
        send(synth_loss_pkg::PDU_1SL, 1'b0, 3'h5, 13'h0A5, 13'h0, 32'h0, 1'b1);
        chk(result_ok, 1);
        chk(peer_rx_loss_count[2*32+:32], 1);
        chk(peer_tx_loss_count[2*32+:32], 1);
    endtask : t_1sl
    task automatic t_hier();
        for (int n = 0; n < 2; n++) begin
            @(posedge clk) server_synthetic_enable <= n == 0;
            port_synthetic_enable <= n == 0;
            send(synth_loss_pkg::PDU_OTHER, 1'b0, 3'h0, 13'h0, 13'h0, 32'h0, 1'b1);
            chk({server_count_data, port_count_data}, n * 3);
        end
        send(synth_loss_pkg::PDU_LMM, 1'b0, 3'h5, 13'h0, 13'h0, 32'h0, 1'b1);
        chk(rx_sticky, 5'h0F);
        @(posedge clk) synthetic_loss_enable <= 1'b0;
        rx_sticky_clear <= 5'h1F;
        @(posedge clk) rx_sticky_clear <= 5'h0;
        send(synth_loss_pkg::PDU_SLM, 1'b0, 3'h5, 13'h0A5, 13'h0, 32'h0, 1'b1);
        chk(rx_sticky, 5'h01);
        chk({server_count_data, port_count_data}, 3);
        chk(peer_rx_loss_count[2*32+:32], 1);
    endtask : t_hier
    task automatic conclude();
        if (miscompares == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_slr();
        t_bad();
        t_tx();
        t_1sl();
        t_hier();
        conclude();
    end
endmodule : tb
